// >>> hw/branch_bitset_consts.vh
// Constants for the branch, bit-set and bit-test-skip decoder.
// Assumes one core clock with a phase counter splitting each instruction cycle in four.
// Summary of operation
// RULE_01 - Top nibble 1101 is the relative jump; low eleven bits are signed offset.
// RULE_02 - Jump target is incremented counter plus twice offset, offset -1024 to 1023.
// RULE_03 - Relative jump is one word, two cycles; second cycle is a no-operation.
// RULE_04 - Relative jump and bit set leave arithmetic status flags untouched.
// RULE_05 - Top nibble 1000 is bit set: bit field, bank selector, eight-bit address.
// RULE_06 - Bit set forces chosen bit to one by read-modify-write in one cycle.
// RULE_07 - Selector 0 uses shared access bank; selector 1 uses bank select register.
// RULE_08 - Selector 0 with extended set treats addresses up to 95 as indexed offset.
// RULE_09 - Top nibble 1011 is test-skip-if-clear with the same field layout.
// RULE_10 - Top nibble 1010 is test-skip-if-set, skipping when tested bit is one.
// RULE_11 - A skip discards the fetched word and runs a no-operation, one or two cycles.
`ifndef BRANCH_BITSET_CONSTS_VH
`define BRANCH_BITSET_CONSTS_VH
`define OPC_JUMP 4'hD
`define OPC_BSET 4'h8
`define OPC_SKIP_CLR 4'hB
`define OPC_SKIP_SET 4'hA
`define OPC_MSB 15
`define OPC_LSB 12
`define OFFS_MSB 10
`define BIT_MSB 11
`define BIT_LSB 9
`define SEL_POS 8
`define FADDR_MSB 7
`define IDX_LIMIT 8'h5F
`define ACCESS_SPLIT 8'h80
`define ACCESS_HIGH_BANK 4'hF
`define PH_Q1 2'h0
`define PH_Q2 2'h1
`define PH_Q3 2'h2
`define PH_Q4 2'h3
`define PC_W 21
`define PC_STEP 21'h000002
`define NOP_NONE 2'h0
`define NOP_ONE 2'h1
`define NOP_TWO 2'h2
`define BIT_ONE 8'h01
`define ADDR_PAD 4'h0
`define PH_STEP 2'h1
`endif

// >>> hw/branch_bitset_decode.v
// Decode and execution of the relative jump, bit set and bit test skip instructions.
// Assumes the fetch unit holds instr stable for a whole instruction cycle and that
// data memory returns rd_data combinationally from data_addr.
`include "branch_bitset_consts.vh"
module branch_bitset_decode (
  input wire clk,
  input wire rst,
  input wire [15:0] instr,
  input wire next_two_word,
  input wire [`PC_W-1:0] pc_in,
  input wire [3:0] bank_select_register,
  input wire [11:0] fsr2,
  input wire ext_set_en,
  input wire [7:0] rd_data,
  output wire [1:0] phase,
  output reg [11:0] data_addr,
  output reg data_rd,
  output reg data_wr,
  output reg [7:0] wr_data,
  output reg pc_load,
  output reg [`PC_W-1:0] pc_value,
  output wire flags_we,
  output reg squash,
  output wire busy
);
  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Tells whether the top nibble of a word matches an opcode.
  function op_is;
    input [15:0] word;
    input [3:0] code;
    begin
      op_is = (word[`OPC_MSB:`OPC_LSB] == code);
    end
  endfunction

  // Jump target: counter of the next word plus the doubled signed offset.
  function [`PC_W-1:0] jump_target;
    input [`PC_W-1:0] pc;
    input [15:0] word;
    reg [`PC_W-1:0] offs;
    begin
      offs = {{(`PC_W-`OFFS_MSB-2){word[`OFFS_MSB]}}, word[`OFFS_MSB:0], 1'b0};
      jump_target = pc + `PC_STEP + offs; // [RULE_02]
    end
  endfunction

  // One-hot mask of the bit that a bit-oriented word selects.
  function [7:0] mask_of;
    input [15:0] word;
    begin
      mask_of = `BIT_ONE << word[`BIT_MSB:`BIT_LSB];
    end
  endfunction

  // Resolves the eight-bit file field into a full data address.
  function [11:0] resolve_addr;
    input [15:0] word;
    input [3:0] bank;
    input [11:0] base;
    input ext_en;
    reg [7:0] f;
    begin
      f = word[`FADDR_MSB:0];
      if (word[`SEL_POS]) begin
        resolve_addr = {bank, f}; // [RULE_07]
      end else if (ext_en && (f <= `IDX_LIMIT)) begin
        resolve_addr = base + {`ADDR_PAD, f}; // [RULE_08]
      end else if (f >= `ACCESS_SPLIT) begin
        resolve_addr = {`ACCESS_HIGH_BANK, f}; // [RULE_07]
      end else begin
        resolve_addr = {`ADDR_PAD, f}; // [RULE_07]
      end
    end
  endfunction

  // Number of no-operation cycles that a taken skip leaves behind.
  function [1:0] skip_nops;
    input two_word;
    begin
      if (two_word) begin
        skip_nops = `NOP_TWO; // [RULE_11]
      end else begin
        skip_nops = `NOP_ONE; // [RULE_11]
      end
    end
  endfunction

  // True when a bit test lands on the outcome that asks for a skip.
  function skip_due;
    input clr_op;
    input set_op;
    input bit_val;
    begin
      skip_due = (clr_op && !bit_val) || (set_op && bit_val); // [RULE_09] [RULE_10]
    end
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire cycle_end;
  reg [1:0] nop_cnt_reg;
  reg [1:0] nop_cnt_next;
  reg test_bit_reg;
  wire active = (nop_cnt_reg == `NOP_NONE);
  wire relative_jump_op = active && op_is(instr, `OPC_JUMP); // [RULE_01]
  wire file_bit_set_op = active && op_is(instr, `OPC_BSET); // [RULE_05]
  wire test_bit_skip_clear_op = active && op_is(instr, `OPC_SKIP_CLR); // [RULE_09]
  wire test_bit_skip_set_op = active && op_is(instr, `OPC_SKIP_SET); // [RULE_10]
  wire bit_op = file_bit_set_op | test_bit_skip_clear_op | test_bit_skip_set_op;
  wire [7:0] bit_mask = mask_of(instr);
  wire skip_taken = skip_due(test_bit_skip_clear_op, test_bit_skip_set_op, test_bit_reg);

  phase_gen u_phase (
    .clk(clk),
    .rst(rst),
    .phase_reg(phase),
    .cycle_end(cycle_end)
  );

  // None of these instructions touches the arithmetic flags.
  assign flags_we = 1'b0; // [RULE_04]
  assign busy = !active;

  // ----------------------------------------------------------------
  // Address resolution
  // ----------------------------------------------------------------
  always @* begin
    data_addr = resolve_addr(instr, bank_select_register, fsr2, ext_set_en); // [RULE_07]
  end

  // ----------------------------------------------------------------
  // Phase sequencing
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      data_rd <= 1'b0;
      data_wr <= 1'b0;
      wr_data <= 8'h00;
      pc_load <= 1'b0;
      pc_value <= {`PC_W{1'b0}};
      squash <= 1'b0;
      test_bit_reg <= 1'b0;
    end else begin
      data_rd <= 1'b0;
      data_wr <= 1'b0;
      pc_load <= 1'b0;
      squash <= 1'b0;
      case (phase)
        `PH_Q1: begin
          if (bit_op) begin
            data_rd <= 1'b1;
          end
        end
        `PH_Q2: begin
          if (bit_op) begin
            test_bit_reg <= |(rd_data & bit_mask);
            wr_data <= rd_data | bit_mask; // [RULE_06]
          end
        end
        `PH_Q3: begin
          if (file_bit_set_op) begin
            data_wr <= 1'b1; // [RULE_06]
          end
          if (relative_jump_op) begin
            pc_value <= jump_target(pc_in, instr); // [RULE_02]
            pc_load <= 1'b1;
          end
        end
        `PH_Q4: begin
          if (skip_taken) begin
            squash <= 1'b1; // [RULE_11]
          end
        end
        default: begin
          data_rd <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // No-operation counter
  // ----------------------------------------------------------------
  // Counts the dead cycles after a jump or a taken skip; the fetched word
  // is ignored while the count is not zero.
  always @(posedge clk) begin
    if (rst) begin
      nop_cnt_reg <= `NOP_NONE;
    end else begin
      nop_cnt_reg <= nop_cnt_next;
    end
  end

  always @* begin
    nop_cnt_next = nop_cnt_reg;
    if (cycle_end) begin
      if (relative_jump_op) begin
        nop_cnt_next = `NOP_ONE; // [RULE_03]
      end else if (skip_taken) begin
        nop_cnt_next = skip_nops(next_two_word); // [RULE_11]
      end else if (!active) begin
        nop_cnt_next = nop_cnt_reg - `NOP_ONE;
      end
    end
  end
endmodule // branch_bitset_decode

// >>> hw/phase_gen.v
// Four-phase generator for the instruction cycle.
// Assumes the core clock and synchronous reset.
`include "branch_bitset_consts.vh"
module phase_gen (
  input wire clk,
  input wire rst,
  output reg [1:0] phase_reg,
  output wire cycle_end
);
  assign cycle_end = (phase_reg == `PH_Q4);
  always @(posedge clk) begin
    if (rst) begin
      phase_reg <= `PH_Q1;
    end else begin
      phase_reg <= phase_reg + `PH_STEP;
    end
  end
endmodule // phase_gen

// >>> verification/branch_bitset_decode_properties.sv
// Port assertions for the branch, bit-set and bit-test-skip decoder.
// Assumes the constants header on the include path and a sync active-high reset.
`include "branch_bitset_consts.vh"
module decode_checker (
  input wire clk,
  input wire rst,
  input wire [15:0] instr,
  input wire [`PC_W-1:0] pc_in,
  input wire [3:0] bank_select_register,
  input wire [11:0] fsr2,
  input wire ext_set_en,
  input wire [7:0] rd_data,
  input wire [1:0] phase,
  input wire [11:0] data_addr,
  input wire data_rd,
  input wire data_wr,
  input wire [7:0] wr_data,
  input wire pc_load,
  input wire [`PC_W-1:0] pc_value,
  input wire flags_we,
  input wire squash,
  input wire busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire ex = phase == 2'h3 && !busy;
  wire idx = ext_set_en && instr[7:0] <= 8'h5F;
  jump_load_a: assert property (ex && instr[15:12] == 4'hD |-> pc_load) else $error("jump");
  jump_target_a: assert property (pc_load |->
    pc_value == pc_in + 21'h2 + {{9{instr[10]}}, instr[10:0], 1'b0}) else $error("target");
  jump_idle_a: assert property (pc_load |=> busy [*4]) else $error("idle");
  flags_kept_a: assert property (!flags_we) else $error("flags");
  set_write_a: assert property (ex && instr[15:12] == 4'h8 |->
    data_wr && wr_data == (rd_data | 8'h01 << instr[11:9])) else $error("set");
  bank_sel_a: assert property (data_rd && instr[8] |->
    data_addr == {bank_select_register, instr[7:0]}) else $error("bank");
  access_bank_a: assert property (data_rd && !instr[8] && !idx |->
    data_addr == {{4{instr[7]}}, instr[7:0]}) else $error("access");
  indexed_a: assert property (data_rd && !instr[8] && idx |->
    data_addr == fsr2 + {4'h0, instr[7:0]}) else $error("indexed");
  skip_taken_a: assert property (ex && instr[15:13] == 3'h5 && rd_data[instr[11:9]] != instr[12]
    |=> squash ##1 busy [*3]) else $error("skip");
endmodule // decode_checker
bind branch_bitset_decode decode_checker chk_u (.clk(clk), .rst(rst), .instr(instr),
  .pc_in(pc_in), .bank_select_register(bank_select_register), .fsr2(fsr2),
  .ext_set_en(ext_set_en), .rd_data(rd_data), .phase(phase), .data_addr(data_addr),
  .data_rd(data_rd), .data_wr(data_wr), .wr_data(wr_data), .pc_load(pc_load),
  .pc_value(pc_value), .flags_we(flags_we), .squash(squash), .busy(busy));

// >>> verification/branch_bitset_decode_tb.sv
// Self-checking bench for the decoder with random and corner instructions.
// Assumes the design files and constants header are on the include path.
module branch_bitset_decode_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, next_two_word = 1'b0, ext_set_en = 1'b0, sk = 1'b0;
  logic pc_load, data_rd, data_wr, flags_we, squash, busy;
  logic [15:0] instr = 16'h0000;
  logic [20:0] pc_in = 21'h000000, pc_value;
  logic [3:0] bank_select_register = 4'h0;
  logic [11:0] fsr2 = 12'h000, data_addr;
  logic [7:0] rd_data = 8'h00, wr_data;
  logic [1:0] phase;
  logic [31:0] r;
  logic bo;
  integer seed = 61925, mismatches = 0, checks = 0, n, k = 0, nop = 0;
  localparam logic [79:0] corners = 80'hDC00_D3FF_8E5F_B100_A07F;
  localparam logic [15:0] ops = 16'hD8BA;
  branch_bitset_decode dut_u (.clk(clk), .rst(rst), .instr(instr),
    .next_two_word(next_two_word), .pc_in(pc_in), .bank_select_register(bank_select_register),
    .fsr2(fsr2), .ext_set_en(ext_set_en), .rd_data(rd_data), .phase(phase),
    .data_addr(data_addr), .data_rd(data_rd), .data_wr(data_wr), .wr_data(wr_data),
    .pc_load(pc_load), .pc_value(pc_value), .flags_we(flags_we), .squash(squash), .busy(busy));
  initial begin
    forever #5 clk = ~clk;
  end
  function automatic logic [20:0] tgt(input logic [20:0] pc, input logic [15:0] w);
    return pc + 21'h2 + {{9{w[10]}}, w[10:0], 1'b0};
  endfunction
  function automatic logic [11:0] ea(input logic [15:0] w, input logic [3:0] b,
                                     input logic [11:0] f, input logic x);
    if (w[8]) return {b, w[7:0]};
    if (x && w[7:0] <= 8'h5F) return f + {4'h0, w[7:0]};
    return {{4{w[7]}}, w[7:0]};
  endfunction
  task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    for (n = 0; n < 2000; n++) begin
      @(negedge clk);
      bo = !busy && (instr[15:12] == 4'h8 || instr[15:13] == 3'h5);
      if (pc_load) chk("pc_value", tgt(pc_in, instr), pc_value);
      if (phase == 2'h0) chk("squash", {20'h0, sk}, {20'h0, squash});
      if (phase == 2'h0) chk("flags_we", 21'h0, {20'h0, flags_we});
      if (phase == 2'h1) chk("busy", {20'h0, nop != 0}, {20'h0, busy});
      if (phase == 2'h1) chk("data_rd", {20'h0, bo}, {20'h0, data_rd});
      if (phase == 2'h1 && bo)
        chk("data_addr", {9'h0, ea(instr, bank_select_register, fsr2, ext_set_en)},
            {9'h0, data_addr});
      if (phase == 2'h1) next_two_word = $random(seed);
      if (phase == 2'h3) begin
        chk("pc_load", {20'h0, !busy && instr[15:12] == 4'hD}, {20'h0, pc_load});
        chk("data_wr", {20'h0, !busy && instr[15:12] == 4'h8}, {20'h0, data_wr});
        if (data_wr)
          chk("wr_data", {13'h0, rd_data | 8'h01 << instr[11:9]}, {13'h0, wr_data});
        sk = !busy && instr[15:13] == 3'h5 && rd_data[instr[11:9]] != instr[12];
        nop = busy ? nop - 1 : instr[15:12] == 4'hD ? 1 : sk ? 1 + next_two_word : 0;
      end
      if (phase == 2'h0) begin
        r = $random(seed);
        instr = k < 5 ? corners[79 - 16 * k -: 16] : {ops[r[13:12] * 4 +: 4], r[11:0]};
        k++;
        r = $random(seed);
        {ext_set_en, bank_select_register, fsr2, rd_data} = r[24:0];
        pc_in = {r[31:12], 1'b0};
      end
    end
    $display("random run done after %0d clocks", n);
    finish_test();
  end
endmodule // branch_bitset_decode_tb
